// file: wd_device.sv
// Windowed watchdog event manager, device end
`timescale 1ns/1ps
module wd_device
#(
    parameter int TICK_CYCLES = wd_pkg::TICK_CYCLES_DEF
)
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    wd_link_if.device       link,
    input  wire logic [3:0] default_window_length_code,
    input  wire logic [2:0] default_expiry_score_limit,
    input  wire logic       default_timer_enable,
    input  wire logic       default_standby_timer_enable,
    input  wire logic [3:0] default_reset_event_limit,
    input  wire logic       windowed_refresh_select,
    input  wire logic       secure_required,
    input  wire logic       system_on,
    input  wire logic       off_mode,
    input  wire logic       standby,
    output logic            soft_wd_reset,
    output logic            hard_wd_reset,
    output logic            fault_transition
);
    import wd_pkg::*;

    // --------------------------------------------------------------
    // Fault pin synchroniser
    // --------------------------------------------------------------
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;

    // Two stages, then a copy for the falling-edge detect
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= link.host_fault_input_pin_n;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // --------------------------------------------------------------
    // Control state
    // --------------------------------------------------------------
    timer_state_t state, next_state;
    logic        loaded, next_loaded;
    logic        enable, next_enable;
    logic        stby_en, next_stby_en;
    logic        kind_hard, next_kind_hard;
    logic [3:0]  code, next_code;
    logic        pending, next_pending;
    logic [2:0]  score, next_score;
    logic [2:0]  score_limit, next_score_limit;
    logic [3:0]  tally, next_tally;
    logic [3:0]  tally_limit, next_tally_limit;
    logic [17:0] prescale, next_prescale;
    logic [15:0] ms_count, next_ms_count;
    logic        rst_out_n, next_rst_out_n;
    logic [7:0]  rdata, next_rdata;
    logic        next_soft, next_hard, next_fault;

    logic        run_ok;
    logic        clear_req;
    logic        code_change;
    logic        tick;
    logic        fail;
    logic        good;
    logic        ev_int;
    logic        ev_ext;
    logic [16:0] period;
    logic [16:0] ms_plus;

    // Next-state computation for timer, score, tally and registers
    always_comb
    begin
        next_state       = state;
        next_loaded      = loaded;
        next_enable      = enable;
        next_stby_en     = stby_en;
        next_kind_hard   = kind_hard;
        next_code        = code;
        next_pending     = pending;
        next_score       = score;
        next_score_limit = score_limit;
        next_tally       = tally;
        next_tally_limit = tally_limit;
        next_prescale    = prescale;
        next_ms_count    = ms_count;
        next_soft        = 1'b0;
        next_hard        = 1'b0;
        next_fault       = 1'b0;
        next_rst_out_n   = system_on && !off_mode;
        clear_req        = 1'b0;
        code_change      = 1'b0;
        fail             = 1'b0;
        good             = 1'b0;
        ev_int           = 1'b0;
        ev_ext           = 1'b0;
        period           = PERIOD_UNIT << code;
        ms_plus          = {1'b0, ms_count} + PERIOD_UNIT;
        tick             = (prescale == 18'(TICK_CYCLES - 1));
        run_ok           = enable && rst_out_n
                           && (!standby || stby_en);
        next_rdata       = RDATA_RST;

        // Read port: data stands one cycle after the strobe
        if (link.reg_rd)
        begin
            case (link.reg_addr)
                ADDR_CTRL:   next_rdata = {5'h00, kind_hard, stby_en, enable};
                ADDR_CONFIG: next_rdata = {4'h0, code};
                ADDR_CLEAR:  next_rdata = {7'h00, pending};
                ADDR_SCORE:  next_rdata = {1'b0, score_limit, 1'b0, score};
                ADDR_EVENT:  next_rdata = {tally_limit, tally};
                default:     next_rdata = RDATA_RST;
            endcase
        end

        if (!loaded)
        begin
            // Defaults taken once after reset release
            next_loaded      = 1'b1;
            next_code        = default_window_length_code;
            next_enable      = default_timer_enable;
            next_stby_en     = default_standby_timer_enable;
            next_score_limit = default_expiry_score_limit;
            next_tally_limit = default_reset_event_limit;
        end
        else if (off_mode)
        begin
            // Off mode: timer, score and tally start afresh
            next_state    = T_IDLE;
            next_pending  = 1'b0;
            next_prescale = '0;
            next_ms_count = '0;
            next_score    = SCORE_RST;
            next_tally    = TALLY_RST;
        end
        else
        begin
            // Register writes
            if (link.reg_wr)
            begin
                case (link.reg_addr)
                    ADDR_CTRL:
                    begin
                        if (!secure_required || link.reg_secure)
                        begin
                            next_enable  = link.reg_wdata[CTRL_EN_BIT];
                            next_stby_en = link.reg_wdata[CTRL_STBY_BIT];
                        end
                        next_kind_hard = link.reg_wdata[CTRL_KIND_BIT];
                    end
                    ADDR_CONFIG:
                    begin
                        next_code   = link.reg_wdata[3:0];
                        code_change = (link.reg_wdata[3:0] != code);
                    end
                    ADDR_CLEAR:
                        clear_req = link.reg_wdata[CLEAR_BIT] && pending;
                    ADDR_SCORE:
                        next_score_limit = link.reg_wdata[SCORE_LIM_LSB +: 3];
                    ADDR_EVENT:
                    begin
                        next_tally       = link.reg_wdata[3:0];
                        next_tally_limit = link.reg_wdata[EVENT_LIM_LSB +: 4];
                    end
                    default:
                        next_rdata = next_rdata;
                endcase
            end

            // Timer sequencing
            case (state)
                T_IDLE:
                begin
                    if (run_ok)
                    begin
                        next_state    = T_RUN;
                        next_pending  = 1'b1;
                        next_prescale = '0;
                        next_ms_count = '0;
                    end
                end
                T_RUN:
                begin
                    next_prescale = tick ? 18'h0_0000 : prescale + 18'h0_0001;
                    if (!run_ok)
                    begin
                        next_state   = T_IDLE;
                        next_pending = 1'b0;
                    end
                    else if (code_change)
                    begin
                        next_pending  = 1'b1;
                        next_prescale = '0;
                        next_ms_count = '0;
                    end
                    else if (clear_req)
                    begin
                        if (windowed_refresh_select
                            && ({1'b0, ms_count} < (period >> 1)))
                            fail = 1'b1;
                        else
                            good = 1'b1;
                    end
                    else if (tick)
                    begin
                        if (ms_plus == period)
                            fail = 1'b1;
                        else
                            next_ms_count = ms_plus[15:0];
                    end
                end
                default:
                    next_state = T_IDLE;
            endcase

            // Score update and restart of the count
            if (fail || good)
            begin
                next_pending  = 1'b1;
                next_prescale = '0;
                next_ms_count = '0;
            end
            if (good && score != SCORE_RST)
            begin
                next_score = score - 3'h1;
                ev_int     = (next_score == score_limit);
            end
            if (fail)
            begin
                next_score = (score > SCORE_MAX - SCORE_STEP) ?
                             SCORE_MAX : score + SCORE_STEP;
                ev_int     = (next_score >= score_limit)
                             || (score_limit <= EARLY_LIMIT);
            end

            // External fault pin falling edge
            ev_ext = pin_prev && !pin_sync;

            if (ev_int || ev_ext)
            begin
                next_tally = tally + 4'h1;
                next_fault = (next_tally == tally_limit);
                next_hard  = ev_int || kind_hard;
                next_soft  = !next_hard;
            end

            if (next_hard)
            begin
                // Full reload from defaults
                next_state       = T_IDLE;
                next_pending     = 1'b0;
                next_score       = SCORE_RST;
                next_kind_hard   = 1'b0;
                next_code        = default_window_length_code;
                next_enable      = default_timer_enable;
                next_stby_en     = default_standby_timer_enable;
                next_score_limit = default_expiry_score_limit;
                next_tally_limit = default_reset_event_limit;
            end
            else if (next_soft)
            begin
                // Partial reload; host reset is left untouched
                next_state   = T_IDLE;
                next_pending = 1'b0;
                next_code    = default_window_length_code;
                next_enable  = default_timer_enable;
                next_stby_en = default_standby_timer_enable;
            end
        end
    end

    // Register the control state
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state            <= T_IDLE;
            loaded           <= 1'b0;
            enable           <= 1'b0;
            stby_en          <= 1'b0;
            kind_hard        <= 1'b0;
            code             <= 4'h0;
            pending          <= 1'b0;
            score            <= SCORE_RST;
            score_limit      <= 3'h0;
            tally            <= TALLY_RST;
            tally_limit      <= 4'h0;
            prescale         <= 18'h0_0000;
            ms_count         <= 16'h0000;
            rst_out_n        <= 1'b0;
            rdata            <= RDATA_RST;
            soft_wd_reset    <= 1'b0;
            hard_wd_reset    <= 1'b0;
            fault_transition <= 1'b0;
        end
        else
        begin
            state            <= next_state;
            loaded           <= next_loaded;
            enable           <= next_enable;
            stby_en          <= next_stby_en;
            kind_hard        <= next_kind_hard;
            code             <= next_code;
            pending          <= next_pending;
            score            <= next_score;
            score_limit      <= next_score_limit;
            tally            <= next_tally;
            tally_limit      <= next_tally_limit;
            prescale         <= next_prescale;
            ms_count         <= next_ms_count;
            rst_out_n        <= next_rst_out_n;
            rdata            <= next_rdata;
            soft_wd_reset    <= next_soft;
            hard_wd_reset    <= next_hard;
            fault_transition <= next_fault;
        end
    end

    // Link outputs
    assign link.host_reset_out_n = rst_out_n;
    assign link.reg_rdata        = rdata;

endmodule

// file: wd_pkg.sv
// Shared constants and types for the windowed watchdog and its host end
package wd_pkg;

    // --------------------------------------------------------------
    // Time base
    // --------------------------------------------------------------
    localparam int TICK_TIME_MS    = 1;          // Timer step, ms
    localparam int CLK_PERIOD_PS   = 5000;       // 200 MHz clock
    localparam int PS_PER_MS       = 1000000000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_MS * (PS_PER_MS / CLK_PERIOD_PS);

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_CLEAR  = 3'h2;
    localparam logic [2:0] ADDR_SCORE  = 3'h3;
    localparam logic [2:0] ADDR_EVENT  = 3'h4;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CTRL_EN_BIT   = 0;  // Timer enable
    localparam int CTRL_STBY_BIT = 1;  // Run in standby
    localparam int CTRL_KIND_BIT = 2;  // External fault: 1 hard, 0 soft
    localparam int CLEAR_BIT     = 0;  // Refresh pending, write 1 to clear
    localparam int SCORE_LIM_LSB = 4;  // Score limit at [6:4]
    localparam int EVENT_LIM_LSB = 4;  // Event limit at [7:4]

    // --------------------------------------------------------------
    // Reset values and counts
    // --------------------------------------------------------------
    localparam logic [7:0]  RDATA_RST    = 8'h00;
    localparam logic [2:0]  SCORE_RST    = 3'h0;
    localparam logic [3:0]  TALLY_RST    = 4'h0;
    localparam logic [2:0]  SCORE_STEP   = 3'h2;
    localparam logic [2:0]  SCORE_MAX    = 3'h7;
    localparam logic [2:0]  EARLY_LIMIT  = 3'h2;
    localparam logic [16:0] PERIOD_UNIT  = 17'h0_0001;

    // Timer states
    typedef enum logic [1:0]
    {
        T_IDLE = 2'b01,
        T_RUN  = 2'b10
    } timer_state_t;

endpackage

// file: wd_link_if.sv
// Link between the watchdog device and its host: fault pin, reset, registers
`timescale 1ns/1ps
interface wd_link_if
(
    input wire logic ref_clk,
    input wire logic reset
);
    logic       host_fault_input_pin_n; // Host pulls low on fault
    logic       host_reset_out_n;       // Device holds host in reset
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic       reg_secure;             // Marks a protected write
    logic [7:0] reg_rdata;

    modport device
    (
        input  host_fault_input_pin_n,
        input  reg_addr,
        input  reg_wdata,
        input  reg_wr,
        input  reg_rd,
        input  reg_secure,
        output host_reset_out_n,
        output reg_rdata
    );

    modport host
    (
        output host_fault_input_pin_n,
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        output reg_secure,
        input  host_reset_out_n,
        input  reg_rdata
    );
endinterface

// file: wd_host.sv
// Host end of the watchdog link: register access and fault pin
`timescale 1ns/1ps
module wd_host
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    wd_link_if.host         link,
    input  wire logic [2:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    input  wire logic       cmd_secure,
    input  wire logic       fault_request,
    output logic [7:0]      cmd_rdata,
    output logic            host_in_reset
);
    import wd_pkg::*;

    // --------------------------------------------------------------
    // Request and answer state
    // --------------------------------------------------------------
    logic [2:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic       wr, next_wr;
    logic       rd, next_rd;
    logic       secure, next_secure;
    logic       rd_wait, next_rd_wait;
    logic       pin_n, next_pin_n;
    logic [7:0] next_cmd_rdata;
    logic       rst_meta;
    logic       rst_sync;

    // Forward commands; catch read data two cycles later
    always_comb
    begin
        next_addr      = cmd_addr;
        next_wdata     = cmd_wdata;
        next_wr        = cmd_wr;
        next_rd        = cmd_rd;
        next_secure    = cmd_secure && cmd_wr;
        next_rd_wait   = rd;
        next_pin_n     = !fault_request;
        next_cmd_rdata = rd_wait ? link.reg_rdata : RDATA_RST;
    end

    // Register commands, pin and answer
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            addr      <= 3'h0;
            wdata     <= 8'h00;
            wr        <= 1'b0;
            rd        <= 1'b0;
            secure    <= 1'b0;
            rd_wait   <= 1'b0;
            pin_n     <= 1'b1;
            cmd_rdata <= RDATA_RST;
        end
        else
        begin
            addr      <= next_addr;
            wdata     <= next_wdata;
            wr        <= next_wr;
            rd        <= next_rd;
            secure    <= next_secure;
            rd_wait   <= next_rd_wait;
            pin_n     <= next_pin_n;
            cmd_rdata <= next_cmd_rdata;
        end
    end

    // Host reset from the device, two-stage synchroniser
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rst_meta      <= 1'b0;
            rst_sync      <= 1'b0;
            host_in_reset <= 1'b1;
        end
        else
        begin
            rst_meta      <= link.host_reset_out_n;
            rst_sync      <= rst_meta;
            host_in_reset <= !rst_sync;
        end
    end

    assign link.reg_addr               = addr;
    assign link.reg_wdata              = wdata;
    assign link.reg_wr                 = wr;
    assign link.reg_rd                 = rd;
    assign link.reg_secure             = secure;
    assign link.host_fault_input_pin_n = pin_n;

endmodule

// file: wd_link_properties.sv
// Concurrent checks on the watchdog link and the device event pulses
`timescale 1ns/1ps
module wd_link_properties
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       host_fault_input_pin_n,
    input wire logic       host_reset_out_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       system_on,
    input wire logic       off_mode,
    input wire logic       soft_wd_reset,
    input wire logic       hard_wd_reset,
    input wire logic       fault_transition
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Event causes, kinds and pulses
    // ------------------------------------------------------------
    a_pin_starts_event: assert property (
        $fell(host_fault_input_pin_n) && host_reset_out_n
        |-> ##[2:4] (soft_wd_reset || hard_wd_reset))
        else $error("fault pin gave no event");
    a_one_reset_kind: assert property (
        !(soft_wd_reset && hard_wd_reset))
        else $error("soft and hard reset together");
    a_hard_pulse_short: assert property (
        $rose(hard_wd_reset) |=> !hard_wd_reset)
        else $error("hard reset pulse too long");
    a_fault_with_event: assert property (
        fault_transition |-> (soft_wd_reset || hard_wd_reset))
        else $error("fault transition without event");
    a_soft_keeps_host: assert property (
        soft_wd_reset |-> host_reset_out_n [*4])
        else $error("host reset asserted by soft reset");

    // ------------------------------------------------------------
    // Off mode, host reset and read port
    // ------------------------------------------------------------
    a_host_reset_follow: assert property (
        !$past(reset) |-> host_reset_out_n == $past(system_on && !off_mode))
        else $error("host reset does not follow power state");
    a_off_no_event: assert property (
        off_mode && $past(off_mode) |-> !soft_wd_reset && !hard_wd_reset)
        else $error("event while device off");
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

// file: tb.sv
// Self-checking bench joining the watchdog device and host ends
`timescale 1ns/1ps
module tb;
    import wd_pkg::*;

    logic        ref_clk;
    logic        reset;
    logic [2:0]  cmd_addr;
    logic [7:0]  cmd_wdata;
    logic        cmd_wr;
    logic        cmd_rd;
    logic        cmd_secure;
    logic        fault_request;
    logic        off_mode;
    logic        system_on = 1'b1;
    logic        standby = 1'b0;
    logic        window_sel = 1'b0;
    logic        secure_req = 1'b1;
    logic [7:0]  cmd_rdata;
    logic        host_in_reset;
    logic        soft_wd_reset;
    logic        hard_wd_reset;
    logic        fault_transition;
    logic [7:0]  v;
    int          fail_count;
    int          n_tests;
    // Address, mask and expected value after power-up
    logic [18:0] rows [6] = '{
        {ADDR_CTRL,   8'h03, 8'h02},
        {ADDR_CONFIG, 8'h0f, 8'h05},
        {ADDR_SCORE,  8'h77, 8'h40},
        {ADDR_EVENT,  8'hff, 8'h30},
        {ADDR_CLEAR,  8'h01, 8'h00},
        {3'h7,        8'hff, 8'h00}};

    wd_link_if wd_link_if_i (.ref_clk(ref_clk), .reset(reset));
    wd_device #(.TICK_CYCLES(10)) wd_device_i (.ref_clk(ref_clk),
        .reset(reset), .link(wd_link_if_i), .default_window_length_code(4'h5),
        .default_expiry_score_limit(3'h4), .default_timer_enable(1'b0),
        .default_standby_timer_enable(1'b1), .default_reset_event_limit(4'h3),
        .windowed_refresh_select(window_sel), .secure_required(secure_req),
        .system_on(system_on), .off_mode(off_mode), .standby(standby),
        .soft_wd_reset(soft_wd_reset), .hard_wd_reset(hard_wd_reset),
        .fault_transition(fault_transition));
    wd_host wd_host_i (.ref_clk(ref_clk), .reset(reset), .link(wd_link_if_i),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_secure(cmd_secure),
        .fault_request(fault_request), .cmd_rdata(cmd_rdata),
        .host_in_reset(host_in_reset));
    wd_link_properties wd_link_properties_i (.ref_clk(ref_clk), .reset(reset),
        .host_fault_input_pin_n(wd_link_if_i.host_fault_input_pin_n),
        .host_reset_out_n(wd_link_if_i.host_reset_out_n),
        .reg_rd(wd_link_if_i.reg_rd), .reg_rdata(wd_link_if_i.reg_rdata),
        .system_on(system_on), .off_mode(off_mode),
        .soft_wd_reset(soft_wd_reset), .hard_wd_reset(hard_wd_reset),
        .fault_transition(fault_transition));

    // Clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d,
                      input logic s);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_secure <= s;
        cmd_wr <= 1'b1;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Read answer stands two edges after the host takes the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge ref_clk);
        cmd_rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 d = cmd_rdata;
        @(posedge ref_clk);
    endtask

    // Bounded wait for an event pulse: {fault, hard, soft}
    task automatic wait_ev(output logic [7:0] ev);
        ev = 8'h00;
        for (int i = 0; i < 400 && ev === 8'h00; i++)
        begin
            @(posedge ref_clk);
            #1 ev = {5'h00, fault_transition, hard_wd_reset, soft_wd_reset};
        end
        if (ev === 8'h00)
        begin
            fail_count++;
            close_out();
        end
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        reset = 1'b1;
        {cmd_addr, cmd_wdata, cmd_wr, cmd_rd, cmd_secure} = '0;
        fault_request = 1'b0;
        off_mode = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        foreach (rows[k])
        begin
            rd(rows[k][18:16], v);
            check(v & rows[k][15:8], rows[k][7:0]);
        end
        // Plain write refused, secure write starts an 8 ms timer
        wr(ADDR_CTRL, 8'h01, 1'b0);
        rd(ADDR_CTRL, v);
        check(v & 8'h01, 8'h00);
        wr(ADDR_CONFIG, 8'h03, 1'b0);
        wr(ADDR_CTRL, 8'h03, 1'b1);
        rd(ADDR_CLEAR, v);
        check(v & 8'h01, 8'h01);
        wr(ADDR_CLEAR, 8'h01, 1'b0);
        rd(ADDR_SCORE, v);
        check(v & 8'h07, 8'h00);
        // Missed period adds two, refresh takes one away
        repeat (90) @(posedge ref_clk);
        rd(ADDR_SCORE, v);
        check(v & 8'h07, 8'h02);
        wr(ADDR_CLEAR, 8'h01, 1'b0);
        rd(ADDR_SCORE, v);
        check(v & 8'h07, 8'h01);
        wait_ev(v);
        check(v, 8'h02);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_EVENT, v);
        check(v & 8'h0f, 8'h01);
        rd(ADDR_CTRL, v);
        check(v & 8'h01, 8'h00);
        // Fault pin, soft kind then hard kind reaching the tally limit
        wr(ADDR_CTRL, 8'h02, 1'b1);
        fault_request <= 1'b1;
        wait_ev(v);
        check(v, 8'h01);
        fault_request <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wr(ADDR_CTRL, 8'h06, 1'b1);
        fault_request <= 1'b1;
        wait_ev(v);
        check(v, 8'h06);
        fault_request <= 1'b0;
        // Low score limit: first expiry of a 1 ms timer gives an event
        repeat (6) @(posedge ref_clk);
        wr(ADDR_SCORE, 8'h10, 1'b0);
        wr(ADDR_CONFIG, 8'h00, 1'b0);
        wr(ADDR_CTRL, 8'h03, 1'b1);
        wait_ev(v);
        check(v, 8'h02);
        // Window mode: early clear fails, late clear refreshes
        window_sel <= 1'b1;
        wr(ADDR_CONFIG, 8'h03, 1'b0);
        wr(ADDR_CTRL, 8'h03, 1'b1);
        wr(ADDR_CLEAR, 8'h01, 1'b0);
        rd(ADDR_SCORE, v);
        check(v & 8'h07, 8'h02);
        repeat (50) @(posedge ref_clk);
        wr(ADDR_CLEAR, 8'h01, 1'b0);
        rd(ADDR_SCORE, v);
        check(v & 8'h07, 8'h01);
        // Plain write allowed when unprotected; standby stops the timer
        secure_req <= 1'b0;
        standby <= 1'b1;
        wr(ADDR_CTRL, 8'h01, 1'b0);
        rd(ADDR_CTRL, v);
        check(v & 8'h03, 8'h01);
        rd(ADDR_CLEAR, v);
        check(v & 8'h01, 8'h00);
        standby <= 1'b0;
        secure_req <= 1'b1;
        // Off mode holds the host and clears the tally
        off_mode <= 1'b1;
        system_on <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check({7'h00, host_in_reset}, 8'h01);
        off_mode <= 1'b0;
        system_on <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check({7'h00, host_in_reset}, 8'h00);
        rd(ADDR_EVENT, v);
        check(v & 8'h0f, 8'h00);
        close_out();
    end
endmodule
